// ---- design/bmss_burst_sequencer.v ----
// Contract
// (RQ1) two levels on feedback: lower entry threshold, higher exit threshold
// (RQ2) below entry while not bursting: enter burst mode, stop switching at once
// (RQ3) during burst off, power down a subset of internal blocks
// (RQ4) above exit during burst off: resume switching, start burst on period
// (RQ5) burst on effort outside soft steps is max of feedback and entry threshold
// (RQ6) first burst on after burst entry has no soft-on
// (RQ7) drop below entry during burst on: finish packet cycle count first
// (RQ8) last 7 cycles of a packet use soft-off scaled effort
// (RQ9) soft-off steps 7 down to 1, then burst off
// (RQ10) soft-on steps 1 up to 7, one step per switching cycle
// (RQ11) feedback above entry before soft-off ends: abort into soft-on
// (RQ12) aborted soft-off resumes soft-on from the same step
// (RQ13) later burst on periods apply soft-on over first 7 cycles
// (RQ14) after soft-on, effort is unscaled max until soft-off begins
// (RQ15) above exit during soft-on: cut soft-on short, effort follows feedback
// (RQ16) fractions 1/3, 9/21, 11/21, 13/21, 15/21, 17/21, 19/21
// (RQ17) last pulse of each burst on ends when cap sense equals common mode
// (RQ18) capacitive-region detect off below exit threshold, on above
// (RQ19) burst disabled: never stop below entry, effort still max of both
// (RQ20) static input selects soft step scaling; off means unscaled packets
`timescale 1ns/1ps
`include "bmss_regs.vh"

module bmss_burst_sequencer #(
    parameter DATA_W        = `BMSS_DATA_W,
    parameter PACKET_CYCLES = `BMSS_PACKET_CYCLES,
    parameter CNT_W         = `BMSS_CNT_W
)(
    // clock and reset
    input  wire              clk,
    input  wire              sys_rst,
    // feedback and thresholds
    input  wire [DATA_W-1:0] feedbackReplica,
    input  wire [DATA_W-1:0] burstEntryThreshold,
    input  wire [DATA_W-1:0] burstExitThreshold,
    // power stage events
    input  wire              switchCycleDone,
    input  wire [DATA_W-1:0] resonantCapSense,
    input  wire [DATA_W-1:0] commonModeLevel,
    // static configuration
    input  wire              burstModeEnable,
    input  wire              softStepEnable,
    // control outputs
    output wire              switchEnable,
    output reg  [DATA_W-1:0] controlEffort,
    output reg               burstActive,
    output reg               lowPowerMode,
    output reg               capacitiveRegionDetectEnable,
    output reg  [2:0]        softStep
);

// ------------------------------------------------------------
// constants
// ------------------------------------------------------------
localparam [31:0]      PKT_LAST_32 = PACKET_CYCLES - 1;
localparam [31:0]      PKT_SOFT_32 = PACKET_CYCLES - 7;
localparam [31:0]      PKT_FULL_32 = PACKET_CYCLES;
localparam [CNT_W-1:0] PKT_LAST    = PKT_LAST_32[CNT_W-1:0];
localparam [CNT_W-1:0] PKT_SOFT    = PKT_SOFT_32[CNT_W-1:0];
localparam [CNT_W-1:0] PKT_FULL    = PKT_FULL_32[CNT_W-1:0];
localparam [CNT_W-1:0] CNT_ONE     = {{(CNT_W-1){1'b0}}, 1'b1};
localparam [CNT_W-1:0] CNT_ZERO    = {CNT_W{1'b0}};

// ------------------------------------------------------------
// state
// ------------------------------------------------------------
reg  [2:0]        state;
reg  [2:0]        step;
reg  [CNT_W-1:0]  cycleCount;
reg  [CNT_W-1:0]  exitCount;
reg               firstOn;
reg               stopPending;

reg  [2:0]        next_state;
reg  [2:0]        next_step;
reg  [CNT_W-1:0]  next_cycleCount;
reg  [CNT_W-1:0]  next_exitCount;
reg               next_firstOn;
reg               next_stopPending;

// ------------------------------------------------------------
// threshold comparisons
// ------------------------------------------------------------
wire              belowEntry;
wire              aboveEntry;
wire              aboveExit;
wire              capAtCommonMode;
wire [DATA_W-1:0] pickHigher;
wire [DATA_W-1:0] scaledEffort;
wire [2:0]        scaleStep;
wire              switchingState;
wire              enterBurstNow;
wire              cycleSat;
wire              exitSat;

assign belowEntry      = feedbackReplica < burstEntryThreshold;  // RQ1
assign aboveEntry      = feedbackReplica > burstEntryThreshold;  // RQ1
assign aboveExit       = feedbackReplica > burstExitThreshold;   // RQ1
assign capAtCommonMode = resonantCapSense == commonModeLevel;
assign pickHigher      = aboveEntry ? feedbackReplica : burstEntryThreshold; // RQ5 RQ19
assign cycleSat        = cycleCount == {CNT_W{1'b1}};
assign exitSat         = exitCount == {CNT_W{1'b1}};

// ------------------------------------------------------------
// switching gate
// ------------------------------------------------------------
assign switchingState = (state != `BMSS_ST_BURST_OFF);
assign enterBurstNow  = (state == `BMSS_ST_NORMAL) && burstModeEnable && belowEntry; // RQ2 RQ19
assign switchEnable   = switchingState && !enterBurstNow; // RQ2

// ------------------------------------------------------------
// soft step scaling
// ------------------------------------------------------------
assign scaleStep = ((state == `BMSS_ST_SOFT_ON) || (state == `BMSS_ST_SOFT_OFF) ||
                    (state == `BMSS_ST_LAST_PULSE)) ? step : `BMSS_STEP_NONE; // RQ14

bmss_fraction_scale #(
    .DATA_W (DATA_W)
) u_scale (
    .effortIn  (pickHigher),
    .step      (scaleStep),
    .effortOut (scaledEffort)
); // RQ16

// ------------------------------------------------------------
// next state
// ------------------------------------------------------------
always @* begin
    next_state       = state;
    next_step        = step;
    next_cycleCount  = cycleCount;
    next_exitCount   = exitCount;
    next_firstOn     = firstOn;
    next_stopPending = stopPending;

    // packet cycle and exit counters while switching in burst
    if (switchCycleDone && !cycleSat) begin
        next_cycleCount = cycleCount + CNT_ONE;
    end
    if (!aboveExit) begin
        next_exitCount = CNT_ZERO;
    end else if (switchCycleDone && !exitSat) begin
        next_exitCount = exitCount + CNT_ONE;
    end
    if (belowEntry) begin
        next_stopPending = 1'b1; // RQ7
    end

    case (state)
        `BMSS_ST_NORMAL: begin
            next_step        = `BMSS_STEP_NONE;
            next_cycleCount  = CNT_ZERO;
            next_exitCount   = CNT_ZERO;
            next_stopPending = 1'b0;
            if (enterBurstNow) begin
                next_state   = `BMSS_ST_BURST_OFF; // RQ2
                next_firstOn = 1'b1;               // RQ6
            end
        end
        `BMSS_ST_BURST_OFF: begin
            next_cycleCount  = CNT_ZERO;
            next_exitCount   = CNT_ZERO;
            next_stopPending = 1'b0;
            if (aboveExit) begin // RQ4
                next_firstOn = 1'b0;
                if (firstOn || !softStepEnable) begin
                    next_state = `BMSS_ST_BURST_ON;  // RQ6 RQ20
                    next_step  = `BMSS_STEP_NONE;
                end else begin
                    next_state = `BMSS_ST_SOFT_ON;   // RQ13
                    next_step  = `BMSS_STEP_FIRST;   // RQ10
                end
            end
        end
        `BMSS_ST_SOFT_ON: begin
            if (aboveExit) begin
                next_state = `BMSS_ST_BURST_ON; // RQ15
                next_step  = `BMSS_STEP_NONE;
            end else if (switchCycleDone) begin
                if (step == `BMSS_STEP_LAST) begin
                    next_state = `BMSS_ST_BURST_ON; // RQ14
                    next_step  = `BMSS_STEP_NONE;
                end else begin
                    next_step = step + 3'h1; // RQ10
                end
            end
        end
        `BMSS_ST_BURST_ON: begin
            next_step = `BMSS_STEP_NONE;
            if (next_exitCount >= PKT_FULL) begin
                next_state = `BMSS_ST_NORMAL; // leave burst mode
            end else if (next_stopPending && softStepEnable &&
                         (cycleCount >= PKT_SOFT)) begin
                next_state = `BMSS_ST_SOFT_OFF; // RQ8 RQ7
                next_step  = `BMSS_STEP_LAST;   // RQ9
            end else if (next_stopPending && !softStepEnable &&
                         (cycleCount >= PKT_LAST)) begin
                next_state = `BMSS_ST_LAST_PULSE; // RQ7 RQ20
            end
        end
        `BMSS_ST_SOFT_OFF: begin
            if (aboveEntry) begin
                next_state       = `BMSS_ST_SOFT_ON; // RQ11
                next_step        = step;             // RQ12
                next_cycleCount  = CNT_ZERO;
                next_stopPending = 1'b0;
            end else if (switchCycleDone) begin
                next_step = step - 3'h1; // RQ9
                if (step == 3'h2) begin
                    next_state = `BMSS_ST_LAST_PULSE;
                end
            end
        end
        `BMSS_ST_LAST_PULSE: begin
            if (aboveEntry && (step != `BMSS_STEP_NONE)) begin
                next_state       = `BMSS_ST_SOFT_ON; // RQ11 RQ12
                next_cycleCount  = CNT_ZERO;
                next_stopPending = 1'b0;
            end else if (capAtCommonMode) begin
                next_state = `BMSS_ST_BURST_OFF; // RQ17 RQ9
                next_step  = `BMSS_STEP_NONE;
            end
        end
        default: begin
            next_state = `BMSS_ST_NORMAL;
            next_step  = `BMSS_STEP_NONE;
        end
    endcase

    if (!burstModeEnable) begin
        next_state       = `BMSS_ST_NORMAL; // RQ19
        next_step        = `BMSS_STEP_NONE;
        next_stopPending = 1'b0;
    end
end

// ------------------------------------------------------------
// state registers
// ------------------------------------------------------------
always @(posedge clk) begin
    if (sys_rst) begin
        state       <= `BMSS_ST_NORMAL;
        step        <= `BMSS_STEP_NONE;
        cycleCount  <= CNT_ZERO;
        exitCount   <= CNT_ZERO;
        firstOn     <= 1'b0;
        stopPending <= 1'b0;
    end else begin
        state       <= next_state;
        step        <= next_step;
        cycleCount  <= next_cycleCount;
        exitCount   <= next_exitCount;
        firstOn     <= next_firstOn;
        stopPending <= next_stopPending;
    end
end

// ------------------------------------------------------------
// registered outputs
// ------------------------------------------------------------
always @(posedge clk) begin
    if (sys_rst) begin
        controlEffort                <= {DATA_W{1'b0}};
        burstActive                  <= 1'b0;
        lowPowerMode                 <= 1'b0;
        capacitiveRegionDetectEnable <= 1'b0;
        softStep                     <= `BMSS_STEP_NONE;
    end else begin
        controlEffort                <= scaledEffort;                       // RQ5 RQ8
        burstActive                  <= next_state != `BMSS_ST_NORMAL;
        lowPowerMode                 <= next_state == `BMSS_ST_BURST_OFF;   // RQ3
        capacitiveRegionDetectEnable <= aboveExit;                          // RQ18
        softStep                     <= scaleStep;
    end
end

endmodule

// ---- design/bmss_regs.vh ----
`ifndef BMSS_REGS_VH
`define BMSS_REGS_VH

// ------------------------------------------------------------
// data path and packet defaults
// ------------------------------------------------------------
`define BMSS_DATA_W          10
`define BMSS_PACKET_CYCLES   32
`define BMSS_CNT_W           8

// ------------------------------------------------------------
// soft step table, fraction = numerator / denominator
// ------------------------------------------------------------
`define BMSS_STEP_NONE       3'h0
`define BMSS_STEP_FIRST      3'h1
`define BMSS_STEP_LAST       3'h7
`define BMSS_FRAC_DEN        5'h15
`define BMSS_FRAC_FULL       5'h15
`define BMSS_FRAC_STEP1      5'h07
`define BMSS_FRAC_STEP2      5'h09
`define BMSS_FRAC_STEP3      5'h0b
`define BMSS_FRAC_STEP4      5'h0d
`define BMSS_FRAC_STEP5      5'h0f
`define BMSS_FRAC_STEP6      5'h11
`define BMSS_FRAC_STEP7      5'h13

// ------------------------------------------------------------
// sequencer states
// ------------------------------------------------------------
`define BMSS_ST_NORMAL       3'h0
`define BMSS_ST_BURST_OFF    3'h1
`define BMSS_ST_BURST_ON     3'h2
`define BMSS_ST_SOFT_ON      3'h3
`define BMSS_ST_SOFT_OFF     3'h4
`define BMSS_ST_LAST_PULSE   3'h5

`endif

// ---- design/bmss_fraction_scale.v ----
`timescale 1ns/1ps
`include "bmss_regs.vh"

module bmss_fraction_scale #(
    parameter DATA_W = `BMSS_DATA_W
)(
    // operand
    input  wire [DATA_W-1:0] effortIn,
    input  wire [2:0]        step,
    // result
    output wire [DATA_W-1:0] effortOut
);

// ------------------------------------------------------------
// step to numerator
// ------------------------------------------------------------
reg  [4:0]        numerator;
wire [DATA_W+4:0] product;
wire [DATA_W+4:0] quotient;

always @* begin
    case (step)
        3'h1:    numerator = `BMSS_FRAC_STEP1;
        3'h2:    numerator = `BMSS_FRAC_STEP2;
        3'h3:    numerator = `BMSS_FRAC_STEP3;
        3'h4:    numerator = `BMSS_FRAC_STEP4;
        3'h5:    numerator = `BMSS_FRAC_STEP5;
        3'h6:    numerator = `BMSS_FRAC_STEP6;
        3'h7:    numerator = `BMSS_FRAC_STEP7;
        default: numerator = `BMSS_FRAC_FULL;
    endcase
end

// ------------------------------------------------------------
// scale, result never exceeds the operand
// ------------------------------------------------------------
assign product   = {5'h00, effortIn} * {{DATA_W{1'b0}}, numerator};
assign quotient  = product / {{DATA_W{1'b0}}, `BMSS_FRAC_DEN};
assign effortOut = quotient[DATA_W-1:0];

endmodule

// ---- sim/bmss_monitor.sv ----
`timescale 1ns/1ps
`include "bmss_regs.vh"

module bmss_monitor #(
    parameter DATA_W        = `BMSS_DATA_W,
    parameter PACKET_CYCLES = `BMSS_PACKET_CYCLES,
    parameter CNT_W         = `BMSS_CNT_W
)(
    // clock and reset
    input wire              clk,
    input wire              sys_rst,
    // feedback and events
    input wire [DATA_W-1:0] feedbackReplica,
    input wire [DATA_W-1:0] burstEntryThreshold,
    input wire [DATA_W-1:0] burstExitThreshold,
    input wire              switchCycleDone,
    input wire [DATA_W-1:0] resonantCapSense,
    input wire [DATA_W-1:0] commonModeLevel,
    input wire              burstModeEnable,
    input wire              softStepEnable,
    // outputs
    input wire              switchEnable,
    input wire [DATA_W-1:0] controlEffort,
    input wire              burstActive,
    input wire              lowPowerMode,
    input wire              capacitiveRegionDetectEnable,
    input wire [2:0]        softStep
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    function [DATA_W-1:0] mx(input [DATA_W-1:0] a, input [DATA_W-1:0] b);
        mx = (a > b) ? a : b;
    endfunction

    function [DATA_W-1:0] scl(input [DATA_W-1:0] m, input [2:0] s);
        reg [4:0]        n;
        reg [DATA_W+4:0] p;
        n = (s == 3'h0) ? 5'h15 : 5'h05 + {1'b0, s, 1'b0};
        p = ({5'h00, m} * n) / 5'h15;
        scl = p[DATA_W-1:0];
    endfunction

    sequence enterBurst;
        !burstActive && burstModeEnable && feedbackReplica < burstEntryThreshold;
    endsequence
    sequence leaveOff;
        lowPowerMode && feedbackReplica > burstExitThreshold;
    endsequence
    sequence cutShort;
        ##[1:2] softStep == 3'h0;
    endsequence
    // two samples above exit: any soft-off abort has already become soft-on
    sequence aboveTwice;
        feedbackReplica > burstExitThreshold ##1 feedbackReplica > burstExitThreshold;
    endsequence

    chk_burst_entry: assert property (
        enterBurst |-> !switchEnable ##1 burstActive && lowPowerMode)
        else $error("burst entry not taken at once");
    chk_off_quiet: assert property (
        lowPowerMode |-> burstActive && !switchEnable)
        else $error("switching or no burst during low power");
    chk_burst_exit: assert property (
        leaveOff |=> !lowPowerMode && switchEnable)
        else $error("burst off not left above exit level");
    chk_effort_scaled: assert property (
        burstActive && !lowPowerMode && $past(burstActive) && !$past(lowPowerMode)
        && $past(softStep) == softStep
        |-> controlEffort == scl(mx($past(feedbackReplica), $past(burstEntryThreshold)), softStep))
        else $error("burst effort wrong");
    chk_disabled_run: assert property (
        !burstModeEnable |-> switchEnable && !burstActive)
        else $error("stopped with burst mode off");
    chk_disabled_effort: assert property (
        !burstModeEnable && !$past(sys_rst)
        |-> controlEffort == mx($past(feedbackReplica), $past(burstEntryThreshold)))
        else $error("effort not larger of both");
    chk_soft_off: assert property (
        !softStepEnable |-> softStep == 3'h0)
        else $error("soft step with scaling off");
    chk_step_walk: assert property (
        softStep != 3'h0 && $past(softStep) != 3'h0 && softStep != $past(softStep)
        |-> $past(switchCycleDone, 2)
        && (softStep == $past(softStep) + 3'h1 || softStep == $past(softStep) - 3'h1))
        else $error("soft step jumped");
    chk_cap_detect: assert property (
        !$past(sys_rst) |-> capacitiveRegionDetectEnable
        == ($past(feedbackReplica) > $past(burstExitThreshold)))
        else $error("capacitive detect gate wrong");
    chk_soft_cut: assert property (
        aboveTwice ##0 softStep != 3'h0 |-> cutShort)
        else $error("soft on not cut above exit level");
    chk_pulse_end: assert property (
        $rose(lowPowerMode) && $past(burstActive)
        |-> $past(resonantCapSense) == $past(commonModeLevel))
        else $error("last pulse ended off common mode");
endmodule

bind bmss_burst_sequencer bmss_monitor #(
    .DATA_W(DATA_W), .PACKET_CYCLES(PACKET_CYCLES), .CNT_W(CNT_W)
) mon (
    .clk(clk), .sys_rst(sys_rst), .feedbackReplica(feedbackReplica),
    .burstEntryThreshold(burstEntryThreshold), .burstExitThreshold(burstExitThreshold),
    .switchCycleDone(switchCycleDone), .resonantCapSense(resonantCapSense),
    .commonModeLevel(commonModeLevel), .burstModeEnable(burstModeEnable),
    .softStepEnable(softStepEnable), .switchEnable(switchEnable),
    .controlEffort(controlEffort), .burstActive(burstActive), .lowPowerMode(lowPowerMode),
    .capacitiveRegionDetectEnable(capacitiveRegionDetectEnable), .softStep(softStep)
);

// ---- sim/bmss_stage_model.sv ----
`timescale 1ns/1ps

module bmss_stage_model #(
    parameter DATA_W = 10
)(
    // clock and pace
    input  wire              clk,
    input  wire              switchEnable,
    input  wire              slow,
    // power stage events
    output reg               switchCycleDone,
    output reg  [DATA_W-1:0] resonantCapSense,
    output wire [DATA_W-1:0] commonModeLevel
);
    reg  [1:0] phase;
    reg  [2:0] wob;
    wire       edgeNow;

    assign commonModeLevel = {1'b1, {(DATA_W-1){1'b0}}};
    assign edgeNow = switchEnable && (!slow || phase == 2'h2);
    initial begin
        phase = 2'h0;
        wob = 3'h0;
        switchCycleDone = 1'b0;
        resonantCapSense = {DATA_W{1'b0}};
    end
    // cap node meets mid-rail only at the end of a switching cycle
    always @(posedge clk) begin
        phase <= (switchEnable && slow && phase != 2'h2) ? phase + 2'h1 : 2'h0;
        wob <= wob + 3'h1;
        switchCycleDone <= edgeNow;
        resonantCapSense <= edgeNow ? commonModeLevel : commonModeLevel + 10'h001 + wob;
    end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps

module testbench;
    localparam N = 10;
    localparam LO = 0, MID = 1, HI = 2;
    reg        clk, sys_rst, burstModeEnable, softStepEnable, slow;
    reg  [9:0] fb, entryTh, exitTh;
    wire       switchCycleDone, switchEnable, burstActive, lowPowerMode, capDet;
    wire [9:0] capSense, cmLevel, controlEffort;
    wire [2:0] softStep;
    int        error_cnt, n_tests, cycles, i;
    logic[2:0] s;

    bmss_burst_sequencer #(.PACKET_CYCLES(N)) dut (
        .clk(clk), .sys_rst(sys_rst), .feedbackReplica(fb), .burstEntryThreshold(entryTh),
        .burstExitThreshold(exitTh), .switchCycleDone(switchCycleDone),
        .resonantCapSense(capSense), .commonModeLevel(cmLevel),
        .burstModeEnable(burstModeEnable), .softStepEnable(softStepEnable),
        .switchEnable(switchEnable), .controlEffort(controlEffort), .burstActive(burstActive),
        .lowPowerMode(lowPowerMode), .capacitiveRegionDetectEnable(capDet), .softStep(softStep));
    bmss_stage_model stage (
        .clk(clk), .switchEnable(switchEnable), .slow(slow), .switchCycleDone(switchCycleDone),
        .resonantCapSense(capSense), .commonModeLevel(cmLevel));

    always #5 clk = ~clk;

    // ------------------------------------------------------------
    // expectations and helpers
    // ------------------------------------------------------------
    function automatic logic [9:0] expEff(logic [9:0] v, logic [2:0] k);
        int num [8] = '{21, 7, 9, 11, 13, 15, 17, 19};
        return 10'(((v > entryTh ? v : entryTh) * num[k]) / 21);
    endfunction
    function automatic logic [9:0] lvl(int w);
        if (w == LO) return 10'($urandom_range(0, entryTh - 1));
        if (w == MID) return 10'($urandom_range(entryTh + 1, exitTh - 1));
        return 10'($urandom_range(exitTh + 1, 10'h3ff));
    endfunction
    function automatic logic [9:0] sel(int w);
        if (w == 0) return 10'(softStep);
        if (w == 1) return 10'(lowPowerMode);
        return 10'(burstActive);
    endfunction
    task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic drv(int w);
        @(posedge clk) fb <= lvl(w);
        #1;
    endtask
    task automatic waitFor(int w, logic [9:0] v);
        for (int j = 0; j < 400 && sel(w) !== v; j++) tick(1);
    endtask
    task automatic rst(logic be, logic se);
        @(posedge clk) begin
            sys_rst <= 1'b1;
            burstModeEnable <= be;
            softStepEnable <= se;
            fb <= 10'h3ff;
        end
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        clk = 0; sys_rst = 1; burstModeEnable = 1; softStepEnable = 1; slow = 0; fb = 10'h3ff;
        void'($urandom(91));
        entryTh = 10'($urandom_range(10'h40, 10'h7f));
        exitTh = 10'($urandom_range(10'h100, 10'h17f));
        rst(1, 1);
        drv(LO);
        chk("switchEnable", 0, switchEnable);
        tick(1);
        chk("lowPowerMode", 1, lowPowerMode);
        drv(HI);
        drv(MID);
        chk("switchEnable", 1, switchEnable);
        tick(3);
        chk("softStep", 0, softStep);
        chk("controlEffort", expEff(fb, 0), controlEffort);
        drv(LO);
        chk("switchEnable", 1, switchEnable);
        waitFor(0, 7);
        chk("softStep", 7, softStep);
        chk("controlEffort", expEff(fb, 7), controlEffort);
        for (i = 6; i >= 1; i--) begin
            waitFor(0, 10'(i));
            chk("softStep", 10'(i), softStep);
        end
        waitFor(1, 1);
        chk("lowPowerMode", 1, lowPowerMode);
        drv(HI);
        drv(MID);
        for (i = 1; i <= 7; i++) begin
            waitFor(0, 10'(i));
            chk("softStep", 10'(i), softStep);
            chk("controlEffort", expEff(fb, 3'(i)), controlEffort);
        end
        waitFor(0, 0);
        tick(1);
        chk("controlEffort", expEff(fb, 0), controlEffort);
        $display("test soft_packet done");
        @(posedge clk) slow <= 1'b1;
        drv(LO);
        waitFor(0, 5);
        drv(MID);
        tick(1);
        s = softStep;
        for (i = 0; i < 20 && softStep === s; i++) tick(1);
        chk("softStep", 10'(s + 3'h1), softStep);
        waitFor(0, 0);
        drv(LO);
        waitFor(1, 1);
        drv(HI);
        drv(MID);
        waitFor(0, 2);
        drv(HI);
        tick(2);
        chk("softStep", 0, softStep);
        chk("controlEffort", expEff(fb, 0), controlEffort);
        waitFor(2, 0);
        chk("burstActive", 0, burstActive);
        $display("test abort_and_cut done");
        rst(1, 0);
        drv(LO);
        drv(HI);
        drv(MID);
        tick(2);
        drv(LO);
        waitFor(1, 1);
        chk("lowPowerMode", 1, lowPowerMode);
        chk("softStep", 0, softStep);
        $display("test no_soft done");
        rst(0, 1);
        repeat (12) begin
            drv($urandom_range(0, 2));
            tick(1);
            chk("switchEnable", 1, switchEnable);
            chk("controlEffort", expEff(fb, 0), controlEffort);
            chk("capDet", 10'(fb > exitTh), capDet);
        end
        $display("test burst_disabled done");
        print_verdict();
    end
endmodule
